// *** ssp_regs.svh ***
// constants for the synchronous serial port core
// assumes a single 20 MHz mclk domain and no register bus
// Summary of operation
// - separate 16-bit, 8-deep tx and rx fifos
// - tx irq when tx level <=4 or disabled
// - rx irq when rx level >=4
// - timeout irq after 32 idle bit periods
// - new transfer clears timeout unless rx full
// - ninth word into full rx fifo raises overrun
// - clear overrun; unread data then times out
// - maskable sources ORed into combined irq
// - dma requests at four filled or empty
// - dma request holds until matching clear
// - dma requests drop when disabled
// - start when enabled with tx data
// - 4 to 16 bit frames, msb first
// - clock idle level, toggles only in frames
// - spi/microwire frame select low whole frame
// - sync frame pulse one bit before frame
// - sync idle low, data out released
// - sync word to rx fifo after last bit
// - bit rate mclk/(prescale*(1+rate))
// - write one clears overrun or timeout
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define SSP_FIFO_WIDTH 16
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_HALF 4
`define SSP_TIMEOUT_BITS 32
`define SSP_MIN_BITS 4
`define SSP_MAX_BITS 16
`define SSP_MCLK_HZ 20000000
`endif

// *** ssp_pkg.sv ***
// types for the synchronous serial port core
// assumes ssp_regs.svh for numeric constants
package ssp_pkg;
    typedef enum logic [1:0] {
        ssp_fmt_spi = 2'b00,
        ssp_fmt_sync = 2'b01,
        ssp_fmt_uwire = 2'b10
    } ssp_fmt_type;
    typedef enum logic [1:0] {
        ssp_st_idle = 2'b00,
        ssp_st_sync = 2'b01,
        ssp_st_shift = 2'b10,
        ssp_st_tail = 2'b11
    } ssp_state_type;
endpackage

// *** ssp_fifo.sv ***
// one synchronous fifo with level output
// drops a push when full and a pop when empty
`timescale 1ns/1ns
module ssp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // write side
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    // read side
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    // status
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] level_reg;
    wire do_push = push && (level_reg != DEPTH[AW:0]);
    wire do_pop = pop && (level_reg != '0);
    assign rdata = mem[rp_reg];
    assign level = level_reg;
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wp_reg] <= wdata;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            level_reg <= '0;
        end else begin
            if (do_push) wp_reg <= wp_reg + 1'b1;
            if (do_pop) rp_reg <= rp_reg + 1'b1;
            level_reg <= level_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // ssp_fifo

// *** ssp_core.sv ***
// synchronous serial port core, master side framing, fifos, irq, dma
// assumes software writes settings only while port_enable_bit is low
`timescale 1ns/1ns
`include "ssp_regs.svh"
module ssp_core #(
    parameter int WIDTH = `SSP_FIFO_WIDTH,
    parameter int DEPTH = `SSP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // configuration
    input wire logic port_enable_bit,
    input wire logic [1:0] frame_format,
    input wire logic clk_polarity,
    input wire logic [3:0] data_size_m1,
    input wire logic [7:0] prescale_divisor_field,
    input wire logic [7:0] serial_clock_rate_field,
    // fifo access
    input wire logic tx_write,
    input wire logic [WIDTH-1:0] tx_data,
    input wire logic rx_read,
    output logic [WIDTH-1:0] rx_data,
    output logic [3:0] tx_level_out,
    output logic [3:0] rx_level_out,
    // interrupts
    input wire logic [3:0] irq_mask,
    input wire logic overrun_clear_bit,
    input wire logic timeout_clear_bit,
    output logic [3:0] irq_raw_out,
    output logic combined_irq_out,
    // dma
    input wire logic tx_dma_enable_bit,
    input wire logic rx_dma_enable_bit,
    input wire logic tx_dma_clear,
    input wire logic rx_dma_clear,
    output logic tx_dma_burst_request,
    output logic rx_dma_burst_request,
    // serial pins
    output logic serial_clk_out,
    output logic frame_select,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic serial_data_in
);
    localparam int LW = $clog2(DEPTH) + 1;
    localparam logic [LW-1:0] HALF = LW'(`SSP_FIFO_HALF);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);
    localparam logic [5:0] TO_BITS = 6'(`SSP_TIMEOUT_BITS);

    ssp_pkg::ssp_state_type state_reg, state_next;
    logic [LW-1:0] tx_level, rx_level;
    logic [WIDTH-1:0] tx_head;
    logic [WIDTH-1:0] tx_shift_reg, rx_shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] pre_cnt_reg;
    logic [7:0] rate_cnt_reg;
    logic half_reg;
    logic sclk_reg, fss_reg, sdo_reg, sdo_oe_reg;
    logic din_meta_reg, din_sync_reg;
    logic rx_push_reg;
    logic overrun_reg, timeout_reg;
    logic [5:0] idle_cnt_reg;
    logic [3:0] raw_reg;
    logic irq_reg;
    logic txreq_reg, rxreq_reg;
    logic [WIDTH-1:0] rx_word_reg;

    // two-stage sync of the serial input pin
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            din_meta_reg <= serial_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // fifos
    wire start = port_enable_bit && (tx_level != '0);
    wire tx_pop = (state_reg == ssp_pkg::ssp_st_idle) && start;
    wire rx_full = (rx_level == FULL);
    // a read in the same cycle does not let the full fifo take the word, so it is lost without an overrun
    wire rx_store = rx_push_reg && (!rx_full || rx_read);
    ssp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .push(tx_write),
        .wdata(tx_data),
        .pop(tx_pop),
        .rdata(tx_head),
        .level(tx_level)
    );
    ssp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .push(rx_store),
        .wdata(rx_word_reg),
        .pop(rx_read),
        .rdata(rx_data),
        .level(rx_level)
    );

    // bit-rate generator: half bit = prescale*(1+rate)/2 mclk cycles
    wire [7:0] pre_div = {prescale_divisor_field[7:1], 1'b0};
    wire [7:0] pre_half = (pre_div < 8'h02) ? 8'h01 : {1'b0, pre_div[7:1]};
    wire pre_tick = (pre_cnt_reg >= pre_half - 8'h01);
    wire half_tick = pre_tick && (rate_cnt_reg == serial_clock_rate_field);
    wire running = (state_reg != ssp_pkg::ssp_st_idle);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt_reg <= 8'h00;
            rate_cnt_reg <= 8'h00;
        end else if (!running) begin
            pre_cnt_reg <= 8'h00;
            rate_cnt_reg <= 8'h00;
        end else if (pre_tick) begin
            pre_cnt_reg <= 8'h00;
            rate_cnt_reg <= half_tick ? 8'h00 : rate_cnt_reg + 8'h01;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
    end

    // frame sequencer
    wire is_sync = (frame_format == 2'b01);
    wire rise = half_tick && !half_reg;
    wire fall = half_tick && half_reg;
    wire last_bit = (bit_cnt_reg == 4'h0);
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ssp_pkg::ssp_st_idle: begin
                if (start) state_next = is_sync ?
                    ssp_pkg::ssp_st_sync : ssp_pkg::ssp_st_shift;
            end
            ssp_pkg::ssp_st_sync: begin
                if (fall) state_next = ssp_pkg::ssp_st_shift;
            end
            ssp_pkg::ssp_st_shift: begin
                if (fall && last_bit) state_next = ssp_pkg::ssp_st_tail;
            end
            ssp_pkg::ssp_st_tail: begin
                if (fall) state_next = ssp_pkg::ssp_st_idle;
            end
            default: state_next = ssp_pkg::ssp_st_idle;
        endcase
    end

    wire [WIDTH-1:0] msb_mask = WIDTH'(1) << data_size_m1;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ssp_pkg::ssp_st_idle;
            half_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            tx_shift_reg <= '0;
            rx_shift_reg <= '0;
            rx_word_reg <= '0;
            rx_push_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rx_push_reg <= 1'b0;
            if (!running) half_reg <= 1'b0;
            else if (half_tick) half_reg <= !half_reg;
            if (tx_pop) begin
                tx_shift_reg <= tx_head;
                bit_cnt_reg <= (data_size_m1 < 4'h3) ? 4'h3 : data_size_m1;
            end
            if (state_reg == ssp_pkg::ssp_st_shift && fall) begin
                // sample on the fall tick (falling clock edge, rising in sync format or in spi format with clk_polarity high), msb first
                rx_shift_reg <= {rx_shift_reg[WIDTH-2:0], din_sync_reg};
                tx_shift_reg <= {tx_shift_reg[WIDTH-2:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg - 4'h1;
            end
            if (state_reg == ssp_pkg::ssp_st_tail && rise) begin
                rx_word_reg <= rx_shift_reg & ((msb_mask << 1) - 1'b1);
                rx_push_reg <= 1'b1;
            end
        end
    end

    // pin drivers
    wire shifting = (state_reg == ssp_pkg::ssp_st_shift);
    wire idle_clk = (frame_format == 2'b00) ? clk_polarity : 1'b0;
    // sync format launches data on the rising edge, so its phase is flipped
    wire sclk_phase = is_sync ? !half_reg : half_reg;
    wire [WIDTH-1:0] tx_msb = tx_shift_reg & msb_mask;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sclk_reg <= 1'b0;
            fss_reg <= 1'b1;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
        end else begin
            // clock only toggles while bits move
            sclk_reg <= shifting ? (sclk_phase ^ idle_clk) : idle_clk;
            if (is_sync) begin
                // one bit-wide high pulse before the frame
                fss_reg <= (state_reg == ssp_pkg::ssp_st_sync);
                sdo_oe_reg <= shifting;
            end else begin
                fss_reg <= !running;
                sdo_oe_reg <= port_enable_bit;
            end
            sdo_reg <= shifting && (tx_msb != '0);
        end
    end

    // idle time-out and sticky flags
    wire rx_empty = (rx_level == '0);
    wire to_hit = (idle_cnt_reg == TO_BITS);
    wire bit_end = half_tick && half_reg;
    logic idle_tick_reg;
    logic [15:0] idle_pre_reg;
    wire [15:0] bit_len = 16'(pre_div) * (16'(serial_clock_rate_field) + 16'h1);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            idle_pre_reg <= 16'h0000;
            idle_tick_reg <= 1'b0;
        end else begin
            idle_tick_reg <= 1'b0;
            if (running || idle_pre_reg + 16'h1 >= bit_len) begin
                idle_pre_reg <= 16'h0000;
                idle_tick_reg <= !running;
            end else begin
                idle_pre_reg <= idle_pre_reg + 16'h1;
            end
        end
    end
    wire idle_rst = running || rx_empty || rx_read;
    // one-cycle set event, so a held hit never masks a later clear
    wire to_set = idle_tick_reg && !idle_rst
        && (idle_cnt_reg == TO_BITS - 6'h01);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_reg <= 6'h00;
            timeout_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            // a clear restarts the idle count
            if (idle_rst || overrun_clear_bit || timeout_clear_bit) begin
                idle_cnt_reg <= 6'h00;
            end else if (idle_tick_reg && !to_hit) begin
                idle_cnt_reg <= idle_cnt_reg + 6'h01;
            end
            // set wins over clear on every flag
            if (to_set) begin
                timeout_reg <= 1'b1;
            end else if (timeout_clear_bit) begin
                timeout_reg <= 1'b0;
            end else if (tx_pop && !rx_full) begin
                timeout_reg <= 1'b0;
            end
            if (rx_push_reg && rx_full && !rx_read) begin
                overrun_reg <= 1'b1;
            end else if (overrun_clear_bit) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    // interrupt combine, raw order: tx, rx, timeout, overrun
    wire [3:0] raw_next = {(tx_level <= HALF) || !port_enable_bit,
                           rx_level >= HALF,
                           timeout_reg, overrun_reg};
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            raw_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            raw_reg <= raw_next;
            irq_reg <= |(raw_next & irq_mask);
        end
    end

    // dma requests, held until the controller clears them
    wire tx_cond = (FULL - tx_level) >= HALF;
    wire rx_cond = rx_level >= HALF;
    logic txclr_reg, rxclr_reg;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            txreq_reg <= 1'b0;
            rxreq_reg <= 1'b0;
            txclr_reg <= 1'b0;
            rxclr_reg <= 1'b0;
        end else begin
            txclr_reg <= tx_dma_clear;
            rxclr_reg <= rx_dma_clear;
            if (!port_enable_bit || !tx_dma_enable_bit) begin
                txreq_reg <= 1'b0;
            end else if (tx_dma_clear) begin
                txreq_reg <= 1'b0;
            end else if (tx_cond && !txclr_reg) begin
                txreq_reg <= 1'b1;
            end
            if (!port_enable_bit || !rx_dma_enable_bit) begin
                rxreq_reg <= 1'b0;
            end else if (rx_dma_clear) begin
                rxreq_reg <= 1'b0;
            end else if (rx_cond && !rxclr_reg) begin
                rxreq_reg <= 1'b1;
            end
        end
    end

    assign tx_level_out = 4'(tx_level);
    assign rx_level_out = 4'(rx_level);
    assign irq_raw_out = raw_reg;
    assign combined_irq_out = irq_reg;
    assign tx_dma_burst_request = txreq_reg;
    assign rx_dma_burst_request = rxreq_reg;
    assign serial_clk_out = sclk_reg;
    assign frame_select = fss_reg;
    assign serial_data_out = sdo_reg;
    assign serial_data_out_oe = sdo_oe_reg;
endmodule // ssp_core

// *** ssp_props.sv ***
// checker for the serial port core, watching only the core ports
// assumes one mclk domain and an asynchronous active-low nrst
`timescale 1ns/1ns
module ssp_props (
    // clock, reset and settings
    input wire logic mclk,
    input wire logic nrst,
    input wire logic port_enable_bit,
    input wire logic [1:0] frame_format,
    input wire logic clk_polarity,
    input wire logic [7:0] prescale_divisor_field,
    input wire logic [7:0] serial_clock_rate_field,
    // fifo, irq and dma
    input wire logic tx_write,
    input wire logic [3:0] tx_level_out,
    input wire logic [3:0] rx_level_out,
    input wire logic [3:0] irq_mask,
    input wire logic overrun_clear_bit,
    input wire logic [3:0] irq_raw_out,
    input wire logic combined_irq_out,
    input wire logic rx_dma_enable_bit,
    input wire logic rx_dma_clear,
    input wire logic rx_dma_burst_request,
    // serial pins
    input wire logic serial_clk_out,
    input wire logic frame_select,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [16:0] hi_cnt_reg;
    logic [16:0] bit_len;
    logic any_src;
    logic in_sync;
    assign bit_len = 17'({prescale_divisor_field[7:1], 1'b0})
        * (17'(serial_clock_rate_field) + 17'h1);
    assign any_src = |(irq_raw_out & irq_mask);
    assign in_sync = frame_format == ssp_pkg::ssp_fmt_sync;
    // counts pulse cycles; cleared while disabled so a format change is ignored
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt_reg <= 17'h0;
        end else if (frame_select && port_enable_bit && in_sync) begin
            hi_cnt_reg <= hi_cnt_reg + 17'h1;
        end else begin
            hi_cnt_reg <= 17'h0;
        end
    end
    a_tx_irq_level: assert property (
        1'b1 |=> irq_raw_out[3] == ($past(tx_level_out) <= 4'h4
        || !$past(port_enable_bit))) else $error("tx irq level wrong");
    a_rx_irq_level: assert property (
        1'b1 |=> irq_raw_out[2] == ($past(rx_level_out) >= 4'h4))
        else $error("rx irq level wrong");
    a_irq_merge: assert property (
        any_src [*2] |-> combined_irq_out) else $error("irq not merged");
    a_dma_off_rx: assert property (
        !port_enable_bit || !rx_dma_enable_bit |=> !rx_dma_burst_request)
        else $error("rx dma request while off");
    a_dma_hold: assert property (
        rx_dma_burst_request && !rx_dma_clear && port_enable_bit
        && rx_dma_enable_bit |=> rx_dma_burst_request)
        else $error("rx dma request dropped early");
    a_spi_clk_idle: assert property (
        frame_select && frame_format == ssp_pkg::ssp_fmt_spi
        && $stable(clk_polarity) |-> serial_clk_out == clk_polarity)
        else $error("spi idle clock level wrong");
    a_clk_in_frame: assert property (
        !in_sync && port_enable_bit && $changed(serial_clk_out)
        |-> !$past(frame_select)) else $error("clock moved outside frame");
    a_sync_pulse: assert property (
        $fell(frame_select) && port_enable_bit && in_sync
        |-> hi_cnt_reg == bit_len) else $error("sync pulse width wrong");
    a_sync_data_edge: assert property (
        in_sync && serial_data_out_oe && $changed(serial_data_out)
        |-> $rose(serial_clk_out)) else $error("sync data off rising edge");
    a_ovr_clear: assert property (
        overrun_clear_bit |-> ##[1:2] !irq_raw_out[0])
        else $error("overrun not cleared");
    a_tx_push: assert property (
        tx_write && !port_enable_bit |=> tx_level_out ==
        ($past(tx_level_out) == 4'h8 ? 4'h8 : $past(tx_level_out) + 4'h1))
        else $error("tx level wrong after push");
    c_overrun: cover property ($rose(irq_raw_out[0]));
    c_timeout: cover property ($rose(irq_raw_out[1]));
    c_rx_dma: cover property ($rose(rx_dma_burst_request));
endmodule // ssp_props
bind ssp_core ssp_props u_props (.*);

// *** ssp_slave_model.sv ***
// behavioural spi peripheral, clock idle low, capture on rising edge
// assumes the master drives clock and an active-low select
`timescale 1ns/1ns
module ssp_slave_model (
    // serial pins
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    // test side
    input wire logic [4:0] nbits,
    input wire logic [15:0] reply,
    output logic [15:0] got
);
    logic [15:0] out_reg = 16'h0;
    logic [15:0] in_reg = 16'h0;
    // deselected line shows the inverse, never a stale copy
    assign miso = sel_n ? ~out_reg[15] : out_reg[15];
    always @(negedge sel_n) begin
        out_reg <= reply << (5'd16 - nbits);
    end
    always @(posedge sclk) begin
        if (!sel_n) begin
            in_reg <= {in_reg[14:0], mosi};
        end
    end
    always @(negedge sclk) begin
        if (!sel_n) begin
            out_reg <= out_reg << 1;
        end
    end
    always @(posedge sel_n) begin
        got <= in_reg;
    end
endmodule // ssp_slave_model

// *** tb.sv ***
// self-checking bench for the serial port core with a spi peripheral
// assumes 20 MHz mclk; inputs change on the falling edge
`timescale 1ns/1ns
module tb;
    localparam int BIT = 4; // mclk per bit: prescale 2 times 1+1
    logic mclk, nrst, port_enable_bit, clk_polarity, tx_write, rx_read;
    logic overrun_clear_bit, timeout_clear_bit, tx_dma_enable_bit;
    logic rx_dma_enable_bit, tx_dma_clear, rx_dma_clear, serial_data_in;
    logic combined_irq_out, tx_dma_burst_request, rx_dma_burst_request;
    logic serial_clk_out, frame_select, serial_data_out, serial_data_out_oe;
    logic [1:0] frame_format;
    logic [3:0] data_size_m1, irq_mask, tx_level_out, rx_level_out;
    logic [3:0] irq_raw_out;
    logic [7:0] prescale_divisor_field, serial_clock_rate_field;
    logic [15:0] tx_data, rx_data, reply, got, w, mk;
    logic [35:0] rows [3];
    int failures, cmp_count, cyc, i, r, t0, per;
    time t_clk;
    ssp_core dut (.*);
    ssp_slave_model peer (.sclk(serial_clk_out), .sel_n(frame_select),
        .mosi(serial_data_out), .miso(serial_data_in),
        .nbits({1'b0, data_size_m1} + 5'h1), .reply(reply), .got(got));
    always #25 mclk = ~mclk;
    always @(posedge serial_clk_out) begin
        per = int'($time - t_clk);
        t_clk = $time;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        cmp_count++;
        if (a !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [15:0] d);
        tx_write = 1'b1;
        tx_data = d;
        idle(1);
        tx_write = 1'b0;
        idle(1);
    endtask
    task automatic rd();
        rx_read = 1'b1;
        idle(1);
        rx_read = 1'b0;
        idle(1);
    endtask
    initial begin
        rows = '{{4'h3, 16'h0001, 16'h000e}, {4'h7, 16'h00a6, 16'h003d},
            {4'hf, 16'h8003, 16'hc3a5}};
        {mclk, nrst, port_enable_bit, clk_polarity, tx_write, rx_read} = '0;
        {overrun_clear_bit, timeout_clear_bit, tx_dma_enable_bit} = '0;
        {rx_dma_enable_bit, tx_dma_clear, rx_dma_clear} = '0;
        {frame_format, data_size_m1, tx_data, reply} = '0;
        irq_mask = 4'hf;
        prescale_divisor_field = 8'h02;
        serial_clock_rate_field = 8'h01;
        idle(5);
        chk(16'(frame_select), 16'h1);
        chk(16'({serial_clk_out, serial_data_out_oe}), 16'h0);
        nrst = 1'b1;
        idle(1);
        $display("reset test done");
        for (r = 0; r < 3; r++) begin
            {data_size_m1, w, reply} = rows[r];
            mk = 16'hffff >> (4'hf - data_size_m1);
            wr(w);
            port_enable_bit = 1'b1;
            for (i = 0; i < 600 && rx_level_out !== 4'h1; i++) idle(1);
            for (i = 0; i < 99 && frame_select !== 1'b1; i++) idle(1);
            idle(1);
            chk(got & mk, w & mk);
            chk(rx_data & mk, reply & mk);
            chk(16'(per), 16'(BIT * 50));
            rd();
            chk(16'(rx_level_out), 16'h0);
            port_enable_bit = 1'b0;
            $display("row %0d done", r);
        end
        clk_polarity = 1'b1;
        idle(3);
        chk(16'(serial_clk_out), 16'h1);
        clk_polarity = 1'b0;
        frame_format = ssp_pkg::ssp_fmt_sync;
        idle(3);
        chk(16'({serial_clk_out, frame_select, serial_data_out_oe}), 16'h0);
        wr(16'h0055);
        port_enable_bit = 1'b1;
        for (i = 0; i < 600 && rx_level_out !== 4'h1; i++) idle(1);
        chk(16'(rx_level_out), 16'h1);
        rd();
        chk(16'({serial_clk_out, frame_select, serial_data_out_oe}), 16'h0);
        port_enable_bit = 1'b0;
        frame_format = ssp_pkg::ssp_fmt_spi;
        $display("sync frame test done");
        data_size_m1 = 4'h3;
        reply = 16'h0005;
        for (r = 0; r < 9; r++) wr(16'h0003);
        chk(16'(tx_level_out), 16'h8);
        chk(16'(irq_raw_out[3]), 16'h1);
        tx_dma_enable_bit = 1'b1;
        rx_dma_enable_bit = 1'b1;
        idle(2);
        chk(16'({tx_dma_burst_request, rx_dma_burst_request}), 16'h0);
        port_enable_bit = 1'b1;
        for (i = 0; i < 600 && tx_dma_burst_request !== 1'b1; i++) idle(1);
        chk(16'(tx_level_out), 16'h4);
        tx_dma_clear = 1'b1;
        idle(2);
        chk(16'(tx_dma_burst_request), 16'h0);
        tx_dma_clear = 1'b0;
        idle(2);
        chk(16'(tx_dma_burst_request), 16'h1);
        tx_dma_enable_bit = 1'b0;
        idle(2);
        chk(16'(tx_dma_burst_request), 16'h0);
        for (i = 0; i < 600 && rx_dma_burst_request !== 1'b1; i++) idle(1);
        chk(16'(rx_level_out >= 4'h4 && irq_raw_out[2]), 16'h1);
        rx_dma_clear = 1'b1;
        idle(2);
        chk(16'(rx_dma_burst_request), 16'h0);
        rx_dma_clear = 1'b0;
        for (i = 0; i < 800 && rx_level_out !== 4'h8; i++) idle(1);
        wr(16'h0003);
        for (i = 0; i < 200 && irq_raw_out[0] !== 1'b1; i++) idle(1);
        t0 = cyc;
        chk(16'({irq_raw_out[0], rx_level_out}), 16'h18);
        for (i = 0; i < 400 && irq_raw_out[1] !== 1'b1; i++) idle(1);
        chk(16'(cyc - t0 >= 32 * BIT - 2 && cyc - t0 <= 34 * BIT), 16'h1);
        wr(16'h0003);
        for (i = 0; i < 200 && frame_select !== 1'b0; i++) idle(1);
        for (i = 0; i < 200 && frame_select !== 1'b1; i++) idle(1);
        idle(BIT);
        chk(16'(irq_raw_out[1:0]), 16'h3);
        irq_mask = 4'h0;
        idle(3);
        chk(16'(combined_irq_out), 16'h0);
        irq_mask = 4'h2;
        idle(3);
        chk(16'(combined_irq_out), 16'h1);
        overrun_clear_bit = 1'b1;
        timeout_clear_bit = 1'b1;
        idle(1);
        {overrun_clear_bit, timeout_clear_bit} = 2'b00;
        idle(1);
        chk(16'(irq_raw_out[1:0]), 16'h0);
        for (i = 0; i < 33 * BIT && irq_raw_out[1] !== 1'b1; i++) idle(1);
        chk(16'(irq_raw_out[1]), 16'h1);
        port_enable_bit = 1'b0;
        idle(2);
        chk(16'(rx_dma_burst_request), 16'h0);
        for (r = 0; r < 8; r++) begin
            chk(rx_data & 16'h000f, 16'h0005);
            rd();
        end
        idle(2);
        chk(16'({rx_level_out, irq_raw_out[2]}), 16'h0);
        $display("fifo irq dma test done");
        give_verdict();
    end
endmodule // tb
